/* File: hw/acs_defines.vh */
// Behaviour
// - test mode loops rts, serial, holds dsr
// - clearing test mode restores normal operation
// - data bits steered by load flag priority
// - both rate flags load both rates
// - bit 14 sets/clears format load flag
// - format bit 7 write clears its flag
// - bit 13 flag loads interval, auto-clears
// - bit 12 flag loads rx rate, auto-clears
// - bit 11 flag loads tx rate
// - bit 31 write sets all flags
// - format register field layout
// - stop-select picks transmitted stop length
// - receiver checks single stop bit only
// - parity enable and odd/even select
// - parity counts data plus parity bit
// - phase clock divided by four or three
// - length select gives five to eight bits
// - tx buffer bit 7 clears empty flag
// - break refuses transmit buffer loads
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// command bit addresses on the serial bit bus
`define ACS_BIT_RESET 5'h1f
`define ACS_BIT_BRK 5'h11
`define ACS_BIT_RTS 5'h10
`define ACS_BIT_TEST 5'h0f
`define ACS_BIT_LDFMT 5'h0e
`define ACS_BIT_LDIV 5'h0d
`define ACS_BIT_LDRX 5'h0c
`define ACS_BIT_LDTX 5'h0b
`define ACS_BIT_DATA_TOP 5'h0a
`define ACS_BIT_BYTE_TOP 5'h07

// load flag positions inside the flag vector
`define ACS_FLG_FMT 3
`define ACS_FLG_IV 2
`define ACS_FLG_RX 1
`define ACS_FLG_TX 0

// format register fields
`define ACS_FMT_STOP_HI 7
`define ACS_FMT_STOP_LO 6
`define ACS_FMT_PAR_ON 5
`define ACS_FMT_PAR_ODD 4
`define ACS_FMT_PRESC 3
`define ACS_FMT_LEN_HI 1
`define ACS_FMT_LEN_LO 0
`define ACS_RATE_DIV8 10

// reset values
`define ACS_FLAGS_RST 4'hf
`define ACS_FMT_RST 8'h00
`define ACS_IV_RST 8'h00
`define ACS_RATE_RST 11'h000

// time base counts
`define ACS_DIV_FOUR 3'h4
`define ACS_DIV_THREE 3'h3
`define ACS_RATE_PRE_MAX 3'h7
`define ACS_TIMER_PRE 7'h40
`define ACS_TEST_SPEEDUP 7'h20
`define ACS_TIMER_PRE_TEST (`ACS_TIMER_PRE / `ACS_TEST_SPEEDUP)

// stop length in half-bit periods
`define ACS_STOP_HALF_ONE 3'h2
`define ACS_STOP_HALF_1P5 3'h3
`define ACS_STOP_HALF_TWO 3'h4

`endif

/* File: hw/acs_fifo.v */
`timescale 1ns/100ps
module acs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_i,
    input wire nrst_i,
    input wire clear_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // honest full and empty from the word count
    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage array, no reset needed
    always @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // pointers wrap at depth
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (clear_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // acs_fifo

/* File: hw/acs_clkdiv.v */
`timescale 1ns/100ps
`include "acs_defines.vh"
module acs_clkdiv (
    input wire clk_i,
    input wire nrst_i,
    input wire phase_i,
    input wire by_four_i,
    output reg tick_o
);
    reg phase_d_r;
    reg [2:0] cnt_r;
    wire phase_rise;
    wire [2:0] div_n;

    assign phase_rise = phase_i && !phase_d_r;
    assign div_n = by_four_i ? `ACS_DIV_FOUR : `ACS_DIV_THREE;

    // count phase edges, one internal tick every n of them
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_d_r <= 1'b0;
            cnt_r <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            phase_d_r <= phase_i;
            tick_o <= 1'b0;
            if (phase_rise) begin
                if (cnt_r + 3'h1 >= div_n) begin
                    cnt_r <= 3'h0;
                    tick_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
        end
    end
endmodule // acs_clkdiv

/* File: hw/acs_top.v */
`timescale 1ns/100ps
`include "acs_defines.vh"
module acs_top #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire clk_i,
    input wire nrst_i,
    input wire cru_wr_i,
    input wire [4:0] cru_addr_i,
    input wire cru_bit_i,
    input wire phase_clk_i,
    input wire serial_in_i,
    input wire cts_n_i,
    input wire dsr_n_i,
    output reg serial_out_o,
    output reg rts_n_o,
    output reg cts_n_seen_o,
    output reg dsr_n_seen_o,
    output wire tx_buffer_empty_o,
    output wire load_flag_any_o,
    output reg [7:0] rx_data_o,
    output reg rx_valid_o,
    output reg rx_parity_err_o,
    output reg rx_frame_err_o,
    output reg timer_elapsed_o
);
    // transmitter states
    localparam T_IDLE = 5'h01;
    localparam T_START = 5'h02;
    localparam T_DATA = 5'h04;
    localparam T_PAR = 5'h08;
    localparam T_STOP = 5'h10;
    // receiver states
    localparam R_IDLE = 5'h01;
    localparam R_START = 5'h02;
    localparam R_DATA = 5'h04;
    localparam R_PAR = 5'h08;
    localparam R_STOP = 5'h10;

    reg [3:0] flags_r;
    reg loopback_test_select_r;
    reg break_command_r;
    reg rts_on_r;
    reg [7:0] fmt_r;
    reg [7:0] iv_r;
    reg [10:0] rx_rate_r;
    reg [10:0] tx_rate_r;
    reg [6:0] tx_hold_r;
    reg [4:0] tx_state_r;
    reg [2:0] tx_half_r;
    reg [2:0] tx_idx_r;
    reg [7:0] tx_shift_r;
    reg tx_par_r;
    reg [4:0] rx_state_r;
    reg rx_half_r;
    reg [2:0] rx_idx_r;
    reg [7:0] rx_shift_r;
    reg rx_par_r;
    reg [6:0] tm_pre_r;
    reg [7:0] tm_cnt_r;
    reg [2:0] stop_halves;

    wire fint_tick;
    wire soft_rst;
    wire data_wr;
    wire [4:0] tgt;
    wire txb_push;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_pop;
    wire [7:0] fifo_out_data;
    wire [1:0] half_tick;
    wire [21:0] rates;
    wire rx_line;
    wire cts_eff_n;
    wire [2:0] last_idx;
    wire tx_idle;
    wire [6:0] tm_limit;

    // load target: [4] format, [3] interval, [2] rx rate, [1] tx rate, [0] tx buffer
    function [4:0] acs_target;
        input [3:0] flg;
        begin
            if (flg[`ACS_FLG_FMT]) begin
                acs_target = 5'h10;
            end else if (flg[`ACS_FLG_IV]) begin
                acs_target = 5'h08;
            end else if (flg[`ACS_FLG_RX] || flg[`ACS_FLG_TX]) begin
                acs_target = {2'b00, flg[`ACS_FLG_RX], flg[`ACS_FLG_TX], 1'b0};
            end else begin
                acs_target = 5'h01;
            end
        end
    endfunction

    // parity bit for the active length; odd select flips the sense
    function acs_parity;
        input [7:0] data;
        input [1:0] len;
        input odd;
        reg [7:0] mask;
        begin
            mask = 8'hff >> (2'h3 - len);
            acs_parity = (^(data & mask)) ^ odd;
        end
    endfunction

    assign soft_rst = cru_wr_i && (cru_addr_i == `ACS_BIT_RESET);
    assign data_wr = cru_wr_i && (cru_addr_i <= `ACS_BIT_DATA_TOP);
    assign tgt = acs_target(flags_r);
    assign load_flag_any_o = |flags_r;
    assign txb_push = data_wr && tgt[0] && !break_command_r &&
                      (cru_addr_i == `ACS_BIT_BYTE_TOP);
    assign tx_buffer_empty_o = !fifo_out_valid;

    // loopback steering in test mode
    assign rx_line = loopback_test_select_r ? serial_out_o : serial_in_i;
    assign cts_eff_n = loopback_test_select_r ? rts_n_o : cts_n_i;
    assign last_idx = {1'b1, fmt_r[`ACS_FMT_LEN_HI:`ACS_FMT_LEN_LO]};
    assign tx_idle = (tx_state_r == T_IDLE);
    assign fifo_pop = tx_idle && !break_command_r && !cts_eff_n && !soft_rst;
    assign rates = {tx_rate_r, rx_rate_r};

    // command bits, load flags and register loading
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_r <= `ACS_FLAGS_RST;
            loopback_test_select_r <= 1'b0;
            break_command_r <= 1'b0;
            rts_on_r <= 1'b0;
            fmt_r <= `ACS_FMT_RST;
            iv_r <= `ACS_IV_RST;
            rx_rate_r <= `ACS_RATE_RST;
            tx_rate_r <= `ACS_RATE_RST;
            tx_hold_r <= 7'h00;
        end else if (cru_wr_i) begin
            case (cru_addr_i)
                `ACS_BIT_RESET: begin
                    flags_r <= `ACS_FLAGS_RST;
                    break_command_r <= 1'b0;
                    rts_on_r <= 1'b0;
                end
                `ACS_BIT_BRK: break_command_r <= cru_bit_i;
                `ACS_BIT_RTS: rts_on_r <= cru_bit_i;
                `ACS_BIT_TEST: loopback_test_select_r <= cru_bit_i;
                `ACS_BIT_LDFMT: flags_r[`ACS_FLG_FMT] <= cru_bit_i;
                `ACS_BIT_LDIV: flags_r[`ACS_FLG_IV] <= cru_bit_i;
                `ACS_BIT_LDRX: flags_r[`ACS_FLG_RX] <= cru_bit_i;
                `ACS_BIT_LDTX: flags_r[`ACS_FLG_TX] <= cru_bit_i;
                default: begin
                    if (data_wr) begin
                        // format register, bit 2 stored but unused
                        if (tgt[4] && cru_addr_i <= `ACS_BIT_BYTE_TOP) begin
                            fmt_r[cru_addr_i[2:0]] <= cru_bit_i;
                            if (cru_addr_i == `ACS_BIT_BYTE_TOP) begin
                                flags_r[`ACS_FLG_FMT] <= 1'b0;
                            end
                        end
                        if (tgt[3] && cru_addr_i <= `ACS_BIT_BYTE_TOP) begin
                            iv_r[cru_addr_i[2:0]] <= cru_bit_i;
                            if (cru_addr_i == `ACS_BIT_BYTE_TOP) begin
                                flags_r[`ACS_FLG_IV] <= 1'b0;
                            end
                        end
                        if (tgt[2]) begin
                            rx_rate_r[cru_addr_i[3:0]] <= cru_bit_i;
                            if (cru_addr_i == `ACS_BIT_DATA_TOP) begin
                                flags_r[`ACS_FLG_RX] <= 1'b0;
                            end
                        end
                        if (tgt[1]) begin
                            tx_rate_r[cru_addr_i[3:0]] <= cru_bit_i;
                        end
                        // low buffer bits held until bit 7 pushes the word
                        if (tgt[0] && !break_command_r && fifo_in_ready &&
                            cru_addr_i < `ACS_BIT_BYTE_TOP) begin
                            tx_hold_r[cru_addr_i[2:0]] <= cru_bit_i;
                        end
                    end
                end
            endcase
        end
    end

    // internal time base from the phase clock
    acs_clkdiv u_clkdiv (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .phase_i(phase_clk_i),
        .by_four_i(fmt_r[`ACS_FMT_PRESC]),
        .tick_o(fint_tick)
    );

    // transmit buffer words, full refuses further loads
    acs_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_txfifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clear_i(soft_rst),
        .in_valid_i(txb_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i({cru_bit_i, tx_hold_r}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // half-bit rate generators: index 0 receive, 1 transmit
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_rate
            reg [2:0] pre_r;
            reg [9:0] div_r;
            reg half_r;
            wire [10:0] rate;
            wire restart;
            assign rate = rates[gi*11 +: 11];
            assign restart = (gi == 0) ? (rx_state_r == R_IDLE) : soft_rst;
            assign half_tick[gi] = half_r;
            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pre_r <= 3'h0;
                    div_r <= 10'h000;
                    half_r <= 1'b0;
                end else begin
                    half_r <= 1'b0;
                    if (restart) begin
                        pre_r <= 3'h0;
                        div_r <= 10'h000;
                    end else if (fint_tick) begin
                        if (rate[`ACS_RATE_DIV8] && pre_r != `ACS_RATE_PRE_MAX) begin
                            pre_r <= pre_r + 3'h1;
                        end else begin
                            pre_r <= 3'h0;
                            if (div_r + 10'h001 >= rate[9:0]) begin
                                div_r <= 10'h000;
                                half_r <= 1'b1;
                            end else begin
                                div_r <= div_r + 10'h001;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // stop length in half bits
    always @* begin
        case (fmt_r[`ACS_FMT_STOP_HI:`ACS_FMT_STOP_LO])
            2'b00: stop_halves = `ACS_STOP_HALF_1P5;
            2'b01: stop_halves = `ACS_STOP_HALF_TWO;
            default: stop_halves = `ACS_STOP_HALF_ONE;
        endcase
    end

    // transmitter: start, data lsb first, parity, stop
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_state_r <= T_IDLE;
            tx_half_r <= 3'h0;
            tx_idx_r <= 3'h0;
            tx_shift_r <= 8'h00;
            tx_par_r <= 1'b0;
            serial_out_o <= 1'b1;
        end else if (soft_rst) begin
            tx_state_r <= T_IDLE;
            serial_out_o <= 1'b1;
        end else begin
            case (tx_state_r)
                T_IDLE: begin
                    serial_out_o <= !break_command_r; // break holds line low
                    if (fifo_pop && fifo_out_valid) begin
                        tx_shift_r <= fifo_out_data;
                        tx_par_r <= acs_parity(fifo_out_data,
                            fmt_r[`ACS_FMT_LEN_HI:`ACS_FMT_LEN_LO],
                            fmt_r[`ACS_FMT_PAR_ODD]);
                        tx_half_r <= 3'h0;
                        tx_idx_r <= 3'h0;
                        serial_out_o <= 1'b0;
                        tx_state_r <= T_START;
                    end
                end
                T_START, T_DATA, T_PAR: begin
                    if (half_tick[1]) begin
                        tx_half_r <= tx_half_r + 3'h1;
                        if (tx_half_r == 3'h1) begin
                            tx_half_r <= 3'h0;
                            if (tx_state_r == T_DATA && tx_idx_r != last_idx) begin
                                tx_idx_r <= tx_idx_r + 3'h1;
                                serial_out_o <= tx_shift_r[tx_idx_r + 3'h1];
                            end else if (tx_state_r == T_START) begin
                                serial_out_o <= tx_shift_r[0];
                                tx_state_r <= T_DATA;
                            end else if (tx_state_r == T_DATA &&
                                         fmt_r[`ACS_FMT_PAR_ON]) begin
                                serial_out_o <= tx_par_r;
                                tx_state_r <= T_PAR;
                            end else begin
                                serial_out_o <= 1'b1;
                                tx_state_r <= T_STOP;
                            end
                        end
                    end
                end
                T_STOP: begin
                    if (half_tick[1]) begin
                        tx_half_r <= tx_half_r + 3'h1;
                        if (tx_half_r + 3'h1 >= stop_halves) begin
                            tx_half_r <= 3'h0;
                            tx_state_r <= T_IDLE;
                        end
                    end
                end
                default: tx_state_r <= T_IDLE;
            endcase
        end
    end

    // receiver: mid-start check, then samples every full bit
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_state_r <= R_IDLE;
            rx_half_r <= 1'b0;
            rx_idx_r <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_data_o <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_parity_err_o <= 1'b0;
            rx_frame_err_o <= 1'b0;
        end else if (soft_rst) begin
            rx_state_r <= R_IDLE;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            case (rx_state_r)
                R_IDLE: begin
                    if (!rx_line) begin
                        rx_state_r <= R_START;
                    end
                end
                R_START: begin
                    if (half_tick[0]) begin
                        rx_half_r <= 1'b0;
                        rx_idx_r <= 3'h0;
                        rx_shift_r <= 8'h00;
                        rx_state_r <= rx_line ? R_IDLE : R_DATA;
                    end
                end
                R_DATA, R_PAR, R_STOP: begin
                    if (half_tick[0]) begin
                        rx_half_r <= !rx_half_r;
                        if (rx_half_r) begin
                            if (rx_state_r == R_DATA) begin
                                rx_shift_r[rx_idx_r] <= rx_line;
                                rx_idx_r <= rx_idx_r + 3'h1;
                                if (rx_idx_r == last_idx) begin
                                    rx_state_r <= fmt_r[`ACS_FMT_PAR_ON] ? R_PAR : R_STOP;
                                end
                            end else if (rx_state_r == R_PAR) begin
                                rx_par_r <= rx_line;
                                rx_state_r <= R_STOP;
                            end else begin
                                // one stop bit checked whatever the select
                                rx_data_o <= rx_shift_r;
                                rx_valid_o <= 1'b1;
                                rx_frame_err_o <= !rx_line;
                                rx_parity_err_o <= fmt_r[`ACS_FMT_PAR_ON] &&
                                    (rx_par_r != acs_parity(rx_shift_r,
                                    fmt_r[`ACS_FMT_LEN_HI:`ACS_FMT_LEN_LO],
                                    fmt_r[`ACS_FMT_PAR_ODD]));
                                rx_state_r <= R_IDLE;
                            end
                        end
                    end
                end
                default: rx_state_r <= R_IDLE;
            endcase
        end
    end

    // interval timer, prescale shortened in test mode
    assign tm_limit = loopback_test_select_r ? `ACS_TIMER_PRE_TEST : `ACS_TIMER_PRE;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tm_pre_r <= 7'h00;
            tm_cnt_r <= 8'h00;
            timer_elapsed_o <= 1'b0;
        end else begin
            timer_elapsed_o <= 1'b0;
            if (soft_rst) begin
                tm_pre_r <= 7'h00;
                tm_cnt_r <= 8'h00;
            end else if (fint_tick) begin
                if (tm_pre_r + 7'h01 >= tm_limit) begin
                    tm_pre_r <= 7'h00;
                    if (tm_cnt_r + 8'h01 == iv_r) begin
                        tm_cnt_r <= 8'h00;
                        timer_elapsed_o <= 1'b1;
                    end else begin
                        tm_cnt_r <= tm_cnt_r + 8'h01;
                    end
                end else begin
                    tm_pre_r <= tm_pre_r + 7'h01;
                end
            end
        end
    end

    // modem lines: rts drops only once transmission has drained
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rts_n_o <= 1'b1;
            cts_n_seen_o <= 1'b1;
            dsr_n_seen_o <= 1'b1;
        end else begin
            if (rts_on_r) begin
                rts_n_o <= 1'b0;
            end else if (tx_idle && !fifo_out_valid && !break_command_r) begin
                rts_n_o <= 1'b1;
            end
            cts_n_seen_o <= cts_eff_n;
            dsr_n_seen_o <= loopback_test_select_r ? 1'b0 : dsr_n_i;
        end
    end
endmodule // acs_top

/* File: dv/acs_far_end.sv */
`timescale 1ns/100ps
// far serial end: quarter-rate phase clock and a one-cycle echo of the line
module acs_far_end (
    input wire logic clk_i,
    input wire logic ser_i,
    output logic phase_o,
    output logic ser_o
);
    logic [1:0] ph_r = 2'h0;
    logic echo_r = 1'b1;
    // free running divider, echo idles high
    always @(posedge clk_i) begin
        ph_r <= ph_r + 2'h1;
        echo_r <= ser_i;
    end
    assign phase_o = ph_r[1]; // quarter rate keeps the divided clock slow
    assign ser_o = echo_r;
endmodule // acs_far_end

/* File: dv/acs_top_asserts.sv */
`timescale 1ns/100ps
// pin-level checks of flags, test mode, break and receive pulses
module acs_top_asserts (
    input wire clk_i,
    input wire nrst_i,
    input wire cru_wr_i,
    input wire [4:0] cru_addr_i,
    input wire cru_bit_i,
    input wire dsr_n_i,
    input wire rts_n_o,
    input wire cts_n_seen_o,
    input wire dsr_n_seen_o,
    input wire tx_buffer_empty_o,
    input wire load_flag_any_o,
    input wire rx_valid_o,
    input wire rx_frame_err_o
);
    logic test_r;
    logic brk_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // mirror of the test mode and break command bits
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            test_r <= 1'b0;
            brk_r <= 1'b0;
        end else if (cru_wr_i) begin
            if (cru_addr_i == 5'h0f) test_r <= cru_bit_i;
            if (cru_addr_i == 5'h11) brk_r <= cru_bit_i;
            if (cru_addr_i == 5'h1f) brk_r <= 1'b0;
        end
    end
    sequence s_wr_reset;
        cru_wr_i && cru_addr_i == 5'h1f;
    endsequence
    sequence s_test_held;
        test_r [*3];
    endsequence
    a_soft_reset_flags: assert property (s_wr_reset |-> ##[1:2] load_flag_any_o)
        else $error("flags not set by soft reset");
    a_test_dsr_low: assert property (s_test_held |-> !dsr_n_seen_o)
        else $error("dsr not held in test mode");
    a_test_cts_loop: assert property (s_test_held ##0 $stable(rts_n_o) |-> cts_n_seen_o == rts_n_o)
        else $error("rts not looped to cts");
    a_normal_dsr_pin: assert property (!test_r [*3] |-> dsr_n_seen_o == $past(dsr_n_i))
        else $error("dsr pin not followed");
    a_push_empties: assert property ($fell(tx_buffer_empty_o) |->
        $past(cru_wr_i && cru_addr_i == 5'h07) || $past(cru_wr_i && cru_addr_i == 5'h07, 2))
        else $error("empty fell without bit 7 write");
    a_break_no_load: assert property (brk_r [*2] ##0 tx_buffer_empty_o |=> tx_buffer_empty_o)
        else $error("buffer loaded during break");
    a_frame_with_valid: assert property ($rose(rx_frame_err_o) |-> rx_valid_o)
        else $error("frame error without character");
    a_rx_single_pulse: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("receive pulse too long");
endmodule // acs_top_asserts
bind acs_top acs_top_asserts u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .cru_wr_i(cru_wr_i),
    .cru_addr_i(cru_addr_i), .cru_bit_i(cru_bit_i), .dsr_n_i(dsr_n_i), .rts_n_o(rts_n_o),
    .cts_n_seen_o(cts_n_seen_o), .dsr_n_seen_o(dsr_n_seen_o), .rx_valid_o(rx_valid_o),
    .tx_buffer_empty_o(tx_buffer_empty_o), .load_flag_any_o(load_flag_any_o),
    .rx_frame_err_o(rx_frame_err_o));

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr = 1'b0;
    logic [4:0] adr = 5'h00;
    logic bit_v = 1'b0;
    wire ph, sin, sout, dsr_seen, empty, flags, rxv, perr, ferr, tmr;
    wire [7:0] rxd;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int ticks = 0;
    logic [7:0] fmts [7] = '{8'h80, 8'h81, 8'h42, 8'h07, 8'hb3, 8'ha3, 8'h8b};
    always #12.5 clk_i = ~clk_i;
    acs_far_end u_far (.clk_i(clk_i), .ser_i(sout), .phase_o(ph), .ser_o(sin));
    acs_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cru_wr_i(wr), .cru_addr_i(adr),
        .cru_bit_i(bit_v), .phase_clk_i(ph), .serial_in_i(sin), .cts_n_i(1'b0), .dsr_n_i(1'b1),
        .serial_out_o(sout), .rts_n_o(), .cts_n_seen_o(), .dsr_n_seen_o(dsr_seen),
        .tx_buffer_empty_o(empty), .load_flag_any_o(flags), .rx_data_o(rxd), .rx_valid_o(rxv),
        .rx_parity_err_o(perr), .rx_frame_err_o(ferr), .timer_elapsed_o(tmr));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // multi-bit write upward from address a, then one settle cycle
    task automatic wrn(input logic [4:0] a, input int n, input logic [11:0] v);
        for (int i = 0; i < n; i++) begin
            wr = 1'b1;
            adr = a + 5'(i);
            bit_v = v[i];
            @(posedge clk_i);
            #2;
        end
        wr = 1'b0;
        @(posedge clk_i);
        #2;
    endtask
    // bounded wait for one received character
    task automatic wait_rx(output logic got);
        int k = 0;
        while (rxv !== 1'b1 && k < 1500) begin
            @(posedge clk_i);
            #2;
            k++;
        end
        got = rxv;
        @(posedge clk_i);
        #2;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            wrap_up();
        end
    end
    // count interval pulses away from the launching edge
    always @(negedge clk_i) begin
        if (tmr === 1'b1) ticks++;
    end
    // main sequence
    initial begin
        logic got;
        repeat (3) @(posedge clk_i);
        #2;
        nrst_i = 1'b1;
        chk("flags", flags, 1);
        chk("empty", empty, 1);
        wrn(5'h00, 8, 12'h083);
        chk("iv flag", flags, 1);
        wrn(5'h00, 8, 12'h010);
        chk("rate flags", flags, 1);
        wrn(5'h00, 11, 12'h001);
        chk("tx flag", flags, 1);
        wrn(5'h00, 12, 12'h001);
        chk("flags off", flags, 0);
        foreach (fmts[j]) begin
            wrn(5'h0e, 1, 12'h001);
            chk("fmt flag", flags, 1);
            wrn(5'h00, 8, {4'h0, fmts[j]});
            chk("fmt clear", flags, 0);
            wrn(5'h00, 8, 12'h0a5);
            wait_rx(got);
            chk("rx got", got, 1);
            chk("rx data", rxd, 8'ha5 & (8'hff >> (2'h3 - fmts[j][1:0])));
            chk("parity", perr, 0);
            chk("frame", ferr, 0);
            #2500;
        end
        for (int i = 0; i < 6; i++) wrn(5'h00, 8, 12'h021 + 12'h011 * 12'(i));
        chk("queued", empty, 0);
        for (int i = 0; i < 5; i++) begin
            wait_rx(got);
            chk("fifo data", rxd, 8'h21 + 8'h11 * 8'(i));
        end
        wait_rx(got);
        chk("refused", got, 0);
        wrn(5'h0f, 1, 12'h001);
        chk("dsr test", dsr_seen, 0);
        wrn(5'h10, 1, 12'h001);
        ticks = 0;
        #15000;
        chk("timer", ticks > 0, 1);
        wrn(5'h10, 1, 12'h000);
        wrn(5'h0f, 1, 12'h000);
        chk("dsr pin", dsr_seen, 1);
        wrn(5'h11, 1, 12'h001);
        wrn(5'h00, 8, 12'h05a);
        chk("break", empty, 1);
        wrn(5'h11, 1, 12'h000);
        wrn(5'h1f, 1, 12'h000);
        chk("soft reset", flags, 1);
        wrap_up();
    end
endmodule // tb
